// ---- zero_speed_and_flying_start.sv ----
// Zero-speed disable and flying-start sequencer for a motor drive.
// Assumes settings are static, speeds in rpm, run and feedback on this clock.
// How it works
// - Disable inverter when both speeds below zone
// - Exit code 0: ref or actual; 1: ref
// - PID auto also needs error above wake level
// - Delay 0 to 999 s; zero disables immediately
// - Nonzero delay counts, disables on reaching it
// - Condition lost while counting resets the count
// - Restart codes: off, FS, FS+RT, RT
// - Scalar: dead time, fixed frequency, voltage ramp
// - Sensorless: sweep from max speed down, constant current
// - Sweep rate is factor times rotor constant
// - Speed found: switch to vector, accelerate
// - Search current ramps over set time
// - Found indication must persist the filter time
// - Sweep factor 2.0 to 50.0, recommended from rating
// - Sensorless flying start: enable does not magnetize
// - Input function 24 inhibits sensorless flying start
// - Encoder: speed caught during magnetization, then run
// - Dead time counted from run, 0.1-10 s
// - Voltage ramp time 0.2 to 60 s
`timescale 1ns/1ps
`default_nettype none
module zero_speed_and_flying_start
#(
   parameter logic [17:0] TICK_CYCLES = 18'(zsfs_pkg::TICK_CYCLES)
)
(
   // Clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST_N,
   // Zero-speed settings
   input  wire logic        I_ZERO_SPEED_DISABLE_ON,
   input  wire logic        I_ZERO_SPEED_EXIT_SELECT,
   input  wire logic [9:0]  I_ZERO_SPEED_DELAY,
   input  wire logic [15:0] I_ZERO_SPEED_ZONE,
   // Speeds and process regulator
   input  wire logic [15:0] I_SPEED_REFERENCE_VALUE,
   input  wire logic [15:0] I_ACTUAL_SPEED_VALUE,
   input  wire logic [1:0]  I_PID_SELECT,
   input  wire logic        I_PID_AUTOMATIC,
   input  wire logic [16:0] I_PID_ERROR,
   input  wire logic [15:0] I_PID_WAKE_ERROR,
   // Restart settings
   input  wire logic [1:0]  I_RESTART_FUNCTION_SELECT,
   input  wire logic [2:0]  I_CONTROL_MODE_SELECT,
   input  wire logic [15:0] I_MAX_SPEED_LIMIT,
   input  wire logic [9:0]  I_VOLTAGE_RAMP_TIME,
   input  wire logic [6:0]  I_DEMAG_DEAD_TIME,
   input  wire logic [8:0]  I_SWEEP_RATE_FACTOR,
   input  wire logic [15:0] I_ROTOR_TIME_CONSTANT,
   input  wire logic [9:0]  I_SEARCH_CURRENT_RAMP_TIME,
   input  wire logic [9:0]  I_SPEED_FOUND_FILTER_TIME,
   input  wire logic [5:0]  I_MOTOR_RATING_CODE,
   // Digital inputs
   input  wire logic [39:0] I_DIGITAL_INPUT_FUNCTION,
   input  wire logic [7:0]  I_DIGITAL_INPUT,
   // Commands and feedback
   input  wire logic        I_RUN_COMMAND,
   input  wire logic        I_GENERAL_ENABLE,
   input  wire logic        I_SPEED_MATCH,
   input  wire logic        I_MAGNETIZATION_DONE,
   // Drive outputs
   output logic             O_PULSE_ENABLE,
   output logic             O_ZERO_SPEED_DISABLED,
   output logic             O_MAGNETIZE,
   output logic             O_SEARCH_ACTIVE,
   output logic             O_VECTOR_CONTROL,
   output logic [15:0]      O_OUTPUT_FREQUENCY,
   output logic [6:0]       O_RAMP_PERCENT,
   output logic [15:0]      O_START_SPEED,
   output logic [6:0]       O_STATE,
   output logic [8:0]       O_RECOMMENDED_SWEEP_FACTOR
);

   typedef struct packed {
      logic [17:0]      tick_cnt;
      logic [7:0]       di_meta;
      logic [7:0]       di_sync;
      logic [19:0]      zs_cnt;
      logic             zs_dis;
      zsfs_pkg::state_e st;
      logic [15:0]      elapsed;
      logic [9:0]       filt_cnt;
      logic [31:0]      sweep_acc;
      logic [15:0]      freq;
      logic [6:0]       level;
      logic [15:0]      start_speed;
      logic             pulse_en;
      logic             magnetize;
   } state_s;

   localparam state_s RESET_S = '{st: zsfs_pkg::ST_IDLE, default: '0};

   state_s      s;
   state_s      next_s;
   logic        tick;
   logic        both_below;
   logic        exit_ok;
   logic        pid_gate;
   logic [19:0] delay_ms;
   logic [15:0] dead_ms;
   logic [15:0] vramp_ms;
   logic [15:0] iramp_ms;
   logic [9:0]  filter_ms;
   logic [8:0]  factor;
   logic [31:0] step;
   logic        fs_on;
   logic        sensorless;
   logic        encoder;
   logic [7:0]  di_inhibit;
   logic        inhibit;
   logic [15:0] elapsed_inc;
   logic [15:0] ramp_den;
   logic [22:0] ramp_quot;
   logic [6:0]  ramp_pct;
   logic        found;

   assign tick = s.tick_cnt >= (TICK_CYCLES - 18'h1);

   // Zero-speed conditions, all strict
   assign both_below = (I_SPEED_REFERENCE_VALUE < I_ZERO_SPEED_ZONE)
                     && (I_ACTUAL_SPEED_VALUE < I_ZERO_SPEED_ZONE);
   assign pid_gate = (I_PID_SELECT == zsfs_pkg::PID_ON) && I_PID_AUTOMATIC;
   assign exit_ok = ((I_SPEED_REFERENCE_VALUE > I_ZERO_SPEED_ZONE)
                    || ((I_ZERO_SPEED_EXIT_SELECT == zsfs_pkg::EXIT_REF_OR_ACT)
                        && (I_ACTUAL_SPEED_VALUE > I_ZERO_SPEED_ZONE)))
                  && (!pid_gate
                      || ($signed(I_PID_ERROR) > $signed({1'b0, I_PID_WAKE_ERROR})));

   // Settings clamped to their ranges, converted to ms ticks
   assign delay_ms = 20'(((I_ZERO_SPEED_DELAY > zsfs_pkg::ZS_DELAY_MAX_S)
                          ? zsfs_pkg::ZS_DELAY_MAX_S : I_ZERO_SPEED_DELAY))
                   * zsfs_pkg::MS_PER_S;
   assign dead_ms = 16'((I_DEMAG_DEAD_TIME < zsfs_pkg::DEAD_MIN_DS) ? zsfs_pkg::DEAD_MIN_DS
                    : (I_DEMAG_DEAD_TIME > zsfs_pkg::DEAD_MAX_DS) ? zsfs_pkg::DEAD_MAX_DS
                    : I_DEMAG_DEAD_TIME) * zsfs_pkg::MS_PER_DECI_S;
   assign vramp_ms = 16'((I_VOLTAGE_RAMP_TIME < zsfs_pkg::VRAMP_MIN_DS) ? zsfs_pkg::VRAMP_MIN_DS
                     : (I_VOLTAGE_RAMP_TIME > zsfs_pkg::VRAMP_MAX_DS) ? zsfs_pkg::VRAMP_MAX_DS
                     : I_VOLTAGE_RAMP_TIME) * zsfs_pkg::MS_PER_DECI_S;
   assign iramp_ms = 16'((I_SEARCH_CURRENT_RAMP_TIME > zsfs_pkg::MS_SETTING_MAX)
                         ? zsfs_pkg::MS_SETTING_MAX : I_SEARCH_CURRENT_RAMP_TIME);
   assign filter_ms = (I_SPEED_FOUND_FILTER_TIME > zsfs_pkg::MS_SETTING_MAX)
                      ? zsfs_pkg::MS_SETTING_MAX : I_SPEED_FOUND_FILTER_TIME;
   assign factor = (I_SWEEP_RATE_FACTOR < zsfs_pkg::FACTOR_MIN) ? zsfs_pkg::FACTOR_MIN
                 : (I_SWEEP_RATE_FACTOR > zsfs_pkg::FACTOR_MAX) ? zsfs_pkg::FACTOR_MAX
                 : I_SWEEP_RATE_FACTOR;
   // Sweep decrement per tick, 16 fraction bits of rpm
   assign step = 32'(factor) * 32'(I_ROTOR_TIME_CONSTANT);

   assign fs_on = (I_RESTART_FUNCTION_SELECT == zsfs_pkg::RESTART_FS)
               || (I_RESTART_FUNCTION_SELECT == zsfs_pkg::RESTART_FS_RT);
   assign sensorless = I_CONTROL_MODE_SELECT == zsfs_pkg::MODE_SENSORLESS;
   assign encoder = I_CONTROL_MODE_SELECT == zsfs_pkg::MODE_ENCODER;

   // Inhibit from any input programmed for it, read after the synchroniser
   genvar g;
   generate
      for (g = 0; g < zsfs_pkg::DI_COUNT; g++)
      begin : g_di
         assign di_inhibit[g] = s.di_sync[g]
            && (I_DIGITAL_INPUT_FUNCTION[g*zsfs_pkg::DI_FN_W +: zsfs_pkg::DI_FN_W]
                == zsfs_pkg::DI_FN_CATCH_SPIN_INHIBIT);
      end
   endgenerate
   assign inhibit = |di_inhibit;

   // One divider shared by both ramps; only one ramp runs at a time
   assign elapsed_inc = s.elapsed + 16'h1;
   assign ramp_den = (s.st == zsfs_pkg::ST_VRAMP) ? vramp_ms : iramp_ms;
   assign ramp_quot = (ramp_den == 16'h0) ? 23'(zsfs_pkg::PERCENT_FULL)
                    : (23'(elapsed_inc) * 23'(zsfs_pkg::PERCENT_FULL)) / 23'(ramp_den);
   assign ramp_pct = (ramp_quot >= 23'(zsfs_pkg::PERCENT_FULL))
                     ? zsfs_pkg::PERCENT_FULL : ramp_quot[6:0];
   assign found = I_SPEED_MATCH && ((s.filt_cnt + 10'h1) >= filter_ms);

   always_comb
   begin
      next_s = s;
      next_s.di_meta = I_DIGITAL_INPUT;
      next_s.di_sync = s.di_meta;
      next_s.tick_cnt = tick ? 18'h0 : s.tick_cnt + 18'h1;

      // Zero-speed disable
      if (!I_ZERO_SPEED_DISABLE_ON)
      begin
         next_s.zs_dis = 1'b0;
         next_s.zs_cnt = 20'h0;
      end
      else if (tick)
      begin
         if (s.zs_dis)
         begin
            if (exit_ok)
            begin
               next_s.zs_dis = 1'b0;
            end
         end
         else if (!both_below)
         begin
            next_s.zs_cnt = 20'h0;
         end
         else if ((delay_ms == 20'h0) || ((s.zs_cnt + 20'h1) >= delay_ms))
         begin
            next_s.zs_dis = 1'b1;
            next_s.zs_cnt = 20'h0;
         end
         else
         begin
            next_s.zs_cnt = s.zs_cnt + 20'h1;
         end
      end

      // Start sequencer
      case (s.st)
         zsfs_pkg::ST_IDLE:
         begin
            if (I_RUN_COMMAND)
            begin
               next_s.elapsed = 16'h0;
               next_s.filt_cnt = 10'h0;
               next_s.level = 7'h0;
               if (fs_on && sensorless && !inhibit)
               begin
                  next_s.st = zsfs_pkg::ST_IRAMP;
                  next_s.sweep_acc = {I_MAX_SPEED_LIMIT, 16'h0};
                  next_s.freq = I_MAX_SPEED_LIMIT;
               end
               else if (fs_on && encoder)
               begin
                  next_s.st = zsfs_pkg::ST_MAG;
               end
               else if (fs_on && !sensorless)
               begin
                  next_s.st = zsfs_pkg::ST_DEAD;
               end
               else
               begin
                  next_s.st = zsfs_pkg::ST_RUN;
                  next_s.level = zsfs_pkg::PERCENT_FULL;
               end
            end
         end
         zsfs_pkg::ST_DEAD:
         begin
            if (tick)
            begin
               next_s.elapsed = elapsed_inc;
               if (elapsed_inc >= dead_ms)
               begin
                  next_s.st = zsfs_pkg::ST_VRAMP;
                  next_s.elapsed = 16'h0;
                  next_s.freq = I_SPEED_REFERENCE_VALUE;
               end
            end
         end
         zsfs_pkg::ST_VRAMP, zsfs_pkg::ST_IRAMP:
         begin
            if (tick)
            begin
               next_s.elapsed = elapsed_inc;
               next_s.level = ramp_pct;
               if (ramp_pct == zsfs_pkg::PERCENT_FULL)
               begin
                  next_s.st = (s.st == zsfs_pkg::ST_VRAMP) ? zsfs_pkg::ST_RUN
                                                           : zsfs_pkg::ST_SWEEP;
               end
            end
         end
         zsfs_pkg::ST_SWEEP:
         begin
            if (tick)
            begin
               next_s.sweep_acc = (s.sweep_acc > step) ? s.sweep_acc - step : 32'h0;
               next_s.freq = next_s.sweep_acc[31:zsfs_pkg::SWEEP_FRAC];
               next_s.filt_cnt = I_SPEED_MATCH ? s.filt_cnt + 10'h1 : 10'h0;
               // A sweep that reaches zero means the shaft is at rest
               if (found || (s.sweep_acc == 32'h0))
               begin
                  next_s.st = zsfs_pkg::ST_RUN;
                  next_s.start_speed = s.freq;
               end
            end
         end
         zsfs_pkg::ST_MAG:
         begin
            if (I_MAGNETIZATION_DONE)
            begin
               next_s.st = zsfs_pkg::ST_RUN;
               next_s.start_speed = I_ACTUAL_SPEED_VALUE;
            end
         end
         zsfs_pkg::ST_RUN:
         begin
            next_s.st = zsfs_pkg::ST_RUN;
         end
         default:
         begin
            next_s.st = zsfs_pkg::ST_IDLE;
         end
      endcase

      if (!I_RUN_COMMAND)
      begin
         next_s.st = zsfs_pkg::ST_IDLE;
         next_s.level = 7'h0;
         next_s.freq = 16'h0;
      end

      // No pulses while demagnetizing or held at zero speed
      next_s.pulse_en = I_RUN_COMMAND && !next_s.zs_dis
                     && (next_s.st != zsfs_pkg::ST_IDLE)
                     && (next_s.st != zsfs_pkg::ST_DEAD);
      next_s.magnetize = (I_GENERAL_ENABLE && !(fs_on && sensorless))
                      || (next_s.st == zsfs_pkg::ST_MAG);
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         s <= RESET_S;
      end
      else
      begin
         s <= next_s;
      end
   end

   sweep_factor_lookup u_lookup
   (
      .i_clk         (I_CORE_CLK),
      .i_rst_n       (I_RST_N),
      .i_rating_code (I_MOTOR_RATING_CODE),
      .o_factor      (O_RECOMMENDED_SWEEP_FACTOR)
   );

   assign O_PULSE_ENABLE = s.pulse_en;
   assign O_ZERO_SPEED_DISABLED = s.zs_dis;
   assign O_MAGNETIZE = s.magnetize;
   assign O_SEARCH_ACTIVE = (s.st == zsfs_pkg::ST_IRAMP) || (s.st == zsfs_pkg::ST_SWEEP);
   assign O_VECTOR_CONTROL = (s.st == zsfs_pkg::ST_RUN) && sensorless;
   assign O_OUTPUT_FREQUENCY = s.freq;
   assign O_RAMP_PERCENT = s.level;
   assign O_START_SPEED = s.start_speed;
   assign O_STATE = s.st;

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   a_zs_entry: assert property ($rose(s.zs_dis) |-> $past(tick && both_below))
      else $error("zero-speed disable without both speeds below zone");
   a_zs_exit: assert property ($fell(s.zs_dis) && $past(I_ZERO_SPEED_DISABLE_ON)
                               |-> $past(exit_ok && tick))
      else $error("zero-speed exit without selected condition");
   a_pid_wake: assert property ($fell(s.zs_dis) && $past(I_ZERO_SPEED_DISABLE_ON && pid_gate)
      |-> $past($signed(I_PID_ERROR) > $signed({1'b0, I_PID_WAKE_ERROR})))
      else $error("zero-speed exit with small PID error");
   a_zs_timer: assert property ($rose(s.zs_dis) && $past(delay_ms != 20'h0)
                                |-> ($past(s.zs_cnt) + 20'h1) >= $past(delay_ms))
      else $error("zero-speed disable before delay expired");
   a_zs_reset: assert property (tick && !both_below && !s.zs_dis |=> s.zs_cnt == 20'h0)
      else $error("zero-speed count kept after condition lost");
   a_pulse_off: assert property (s.zs_dis |-> !O_PULSE_ENABLE)
      else $error("pulses enabled during zero-speed disable");
   a_dead_time: assert property ($rose(s.st == zsfs_pkg::ST_VRAMP)
                                 |-> $past(elapsed_inc) >= $past(dead_ms))
      else $error("voltage ramp before dead time");
   a_sweep_start: assert property ((s.st == zsfs_pkg::ST_IRAMP) && $past(s.st == zsfs_pkg::ST_IDLE)
                                   |-> O_OUTPUT_FREQUENCY == $past(I_MAX_SPEED_LIMIT))
      else $error("sweep not started at max speed");
   a_sweep_rate: assert property (s.st == zsfs_pkg::ST_SWEEP && tick && I_RUN_COMMAND
      |=> s.sweep_acc == (($past(s.sweep_acc) > $past(step))
                          ? $past(s.sweep_acc) - $past(step) : 32'h0))
      else $error("sweep step differs from factor times rotor constant");
   a_found_filter: assert property ($rose(s.st == zsfs_pkg::ST_RUN)
      && $past(s.st == zsfs_pkg::ST_SWEEP) && $past(s.sweep_acc != 32'h0)
      |-> ($past(s.filt_cnt) + 10'h1) >= $past(filter_ms))
      else $error("speed found before filter time");
   a_no_magnetize: assert property (fs_on && sensorless && I_GENERAL_ENABLE
      && (next_s.st != zsfs_pkg::ST_MAG) |=> !O_MAGNETIZE)
      else $error("magnetization during sensorless flying start");
   a_inhibit: assert property (s.st == zsfs_pkg::ST_IDLE && I_RUN_COMMAND && sensorless
                               && fs_on && inhibit |=> s.st == zsfs_pkg::ST_RUN)
      else $error("sensorless flying start not inhibited");
   a_encoder_catch: assert property ((s.st == zsfs_pkg::ST_RUN) && $past(s.st == zsfs_pkg::ST_MAG)
                                     |-> O_START_SPEED == $past(I_ACTUAL_SPEED_VALUE))
      else $error("encoder start speed not captured");

   c_zs_disable: cover property ($rose(s.zs_dis) ##[1:300] $fell(s.zs_dis));
   c_sweep_found: cover property (s.st == zsfs_pkg::ST_SWEEP ##1 s.st == zsfs_pkg::ST_RUN);
   c_scalar_start: cover property (s.st == zsfs_pkg::ST_VRAMP ##1 s.st == zsfs_pkg::ST_RUN);
   c_encoder_start: cover property (s.st == zsfs_pkg::ST_MAG ##1 s.st == zsfs_pkg::ST_RUN);

endmodule
`default_nettype wire

// ---- zsfs_pkg.sv ----
// Constants shared by the zero-speed and flying-start logic.
// Assumes a 200 MHz core clock and a 1 ms control-loop tick made from it.
package zsfs_pkg;

   // Clock and control-loop tick
   localparam int          CLK_PERIOD_NS = 5;
   localparam int          CTRL_TICK_NS  = 1000000;
   localparam int          TICK_CYCLES   = CTRL_TICK_NS / CLK_PERIOD_NS;

   // Unit scaling (timers count 1 ms ticks)
   localparam logic [19:0] MS_PER_S      = 20'h003E8;
   localparam logic [15:0] MS_PER_DECI_S = 16'h0064;
   localparam logic [6:0]  PERCENT_FULL  = 7'h64;
   localparam int          SWEEP_FRAC    = 16;

   // Setting ranges
   localparam logic [9:0]  ZS_DELAY_MAX_S = 10'h3E7;
   localparam logic [6:0]  DEAD_MIN_DS    = 7'h01;
   localparam logic [6:0]  DEAD_MAX_DS    = 7'h64;
   localparam logic [9:0]  VRAMP_MIN_DS   = 10'h002;
   localparam logic [9:0]  VRAMP_MAX_DS   = 10'h258;
   localparam logic [9:0]  MS_SETTING_MAX = 10'h3E8;
   localparam logic [8:0]  FACTOR_MIN     = 9'h014;
   localparam logic [8:0]  FACTOR_MAX     = 9'h1F4;

   // Selector codes
   localparam logic [1:0]  RESTART_OFF    = 2'h0;
   localparam logic [1:0]  RESTART_FS     = 2'h1;
   localparam logic [1:0]  RESTART_FS_RT  = 2'h2;
   localparam logic [1:0]  RESTART_RT     = 2'h3;
   localparam logic [2:0]  MODE_SENSORLESS = 3'h3;
   localparam logic [2:0]  MODE_ENCODER   = 3'h4;
   localparam logic        EXIT_REF_OR_ACT = 1'h0;
   localparam logic        EXIT_REF_ONLY  = 1'h1;
   localparam logic [1:0]  PID_ON         = 2'h1;

   // Digital inputs
   localparam int          DI_COUNT       = 8;
   localparam int          DI_FN_W        = 5;
   localparam logic [4:0]  DI_FN_CATCH_SPIN_INHIBIT = 5'h18;

   // Recommended sweep factor (tenths) against motor rating code
   localparam logic [8:0]  FACTOR_BASE    = 9'h03C;
   localparam logic [8:0]  FACTOR_STEP    = 9'h00A;
   localparam int          RATING_EDGES   = 11;
   localparam logic [5:0]  RATING_EDGE [RATING_EDGES] = '{
      6'h14, 6'h17, 6'h1A, 6'h1D, 6'h20, 6'h25, 6'h28, 6'h2C, 6'h30, 6'h31, 6'h32};

   // Start sequencer states
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_DEAD  = 7'h02,
      ST_VRAMP = 7'h04,
      ST_IRAMP = 7'h08,
      ST_SWEEP = 7'h10,
      ST_MAG   = 7'h20,
      ST_RUN   = 7'h40
   } state_e;

endpackage

// ---- sweep_factor_lookup.sv ----
// Recommended sweep rate factor for a motor rating code.
// Assumes the code is a static setting; result is registered.
`timescale 1ns/1ps
`default_nettype none
module sweep_factor_lookup
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Setting in, factor out (tenths)
   input  wire logic [5:0] i_rating_code,
   output logic      [8:0] o_factor
);

   typedef struct packed {
      logic [8:0] factor;
   } state_s;

   state_s                               s;
   state_s                               next_s;
   logic [zsfs_pkg::RATING_EDGES-1:0]    above;

   // One step per table edge passed
   genvar g;
   generate
      for (g = 0; g < zsfs_pkg::RATING_EDGES; g++)
      begin : g_edge
         assign above[g] = i_rating_code > zsfs_pkg::RATING_EDGE[g];
      end
   endgenerate

   always_comb
   begin
      next_s = s;
      next_s.factor = zsfs_pkg::FACTOR_BASE;
      for (int k = 0; k < zsfs_pkg::RATING_EDGES; k++)
      begin
         if (above[k])
         begin
            next_s.factor = next_s.factor + zsfs_pkg::FACTOR_STEP;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign o_factor = s.factor;

endmodule
`default_nettype wire

// ---- motor_stage_model.sv ----
// Behavioural motor, power stage and speed feedback for the start logic.
// Assumes the bench sets the free shaft speed; all on the core clock.
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model
#(
   parameter int MAG_CYCLES = 20
)
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // Drive side
   input  wire logic        i_pulse_enable,
   input  wire logic        i_magnetize,
   input  wire logic [15:0] i_output_frequency,
   input  wire logic [15:0] i_shaft_speed,
   // Feedback
   output logic [15:0]      o_actual_speed,
   output logic             o_speed_match,
   output logic             o_magnetization_done
);
   int mag_count;
   // Observer only sees a match while the bridge is switching
   assign o_speed_match = i_pulse_enable && (i_output_frequency <= i_shaft_speed);
   assign o_actual_speed = i_shaft_speed;
   // Flux builds over a number of cycles, so the answer is slow
   assign o_magnetization_done = (mag_count >= MAG_CYCLES);
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         mag_count <= 0;
      else if (!i_magnetize)
         mag_count <= 0;
      else if (mag_count < MAG_CYCLES)
         mag_count <= mag_count + 1;
   end
endmodule
`default_nettype wire

// ---- zero_speed_and_flying_start_test.sv ----
// Self-checking bench for the zero-speed and flying-start logic.
// Assumes an 8-cycle control tick so all timers run short.
`timescale 1ns/1ps
`default_nettype none
module zero_speed_and_flying_start_test;
   logic I_CORE_CLK = 0, I_RST_N = 0, I_ZERO_SPEED_DISABLE_ON = 0, I_ZERO_SPEED_EXIT_SELECT = 0;
   logic I_PID_AUTOMATIC = 0, I_RUN_COMMAND = 0, I_GENERAL_ENABLE = 0;
   logic [9:0] I_ZERO_SPEED_DELAY = 10'h000, I_VOLTAGE_RAMP_TIME = 10'h002;
   logic [9:0] I_SEARCH_CURRENT_RAMP_TIME = 10'h00A, I_SPEED_FOUND_FILTER_TIME = 10'h005;
   logic [15:0] I_ZERO_SPEED_ZONE = 16'h0064, I_SPEED_REFERENCE_VALUE = 16'h0000;
   logic [15:0] I_PID_WAKE_ERROR = 16'h0014, I_MAX_SPEED_LIMIT = 16'h03E8;
   logic [15:0] I_ROTOR_TIME_CONSTANT = 16'h199A, shaft = 16'h0258;
   logic [1:0] I_PID_SELECT = 2'h0, I_RESTART_FUNCTION_SELECT = 2'h0;
   logic [16:0] I_PID_ERROR = 17'h00000;
   logic [2:0] I_CONTROL_MODE_SELECT = 3'h0;
   logic [6:0] I_DEMAG_DEAD_TIME = 7'h01, O_RAMP_PERCENT, O_STATE;
   logic [8:0] I_SWEEP_RATE_FACTOR = 9'h064, O_RECOMMENDED_SWEEP_FACTOR;
   logic [5:0] I_MOTOR_RATING_CODE = 6'h00;
   logic [39:0] I_DIGITAL_INPUT_FUNCTION = 40'h0000000000;
   logic [7:0] I_DIGITAL_INPUT = 8'h00;
   logic O_PULSE_ENABLE, O_ZERO_SPEED_DISABLED, O_MAGNETIZE, O_SEARCH_ACTIVE, O_VECTOR_CONTROL;
   logic [15:0] O_OUTPUT_FREQUENCY, O_START_SPEED, I_ACTUAL_SPEED_VALUE;
   logic I_SPEED_MATCH, I_MAGNETIZATION_DONE;
   int errors = 0, check_count = 0, cycles = 0, c;
   integer seed = 78199;

   zero_speed_and_flying_start #(.TICK_CYCLES(18'h00008)) uut (.*);
   motor_stage_model partner (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N),
      .i_pulse_enable(O_PULSE_ENABLE), .i_magnetize(O_MAGNETIZE),
      .i_output_frequency(O_OUTPUT_FREQUENCY), .i_shaft_speed(shaft),
      .o_actual_speed(I_ACTUAL_SPEED_VALUE), .o_speed_match(I_SPEED_MATCH),
      .o_magnetization_done(I_MAGNETIZATION_DONE));

   always #2.5 I_CORE_CLK = ~I_CORE_CLK;

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Whole run needs about 15200 cycles
   always @(posedge I_CORE_CLK)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n * 8) @(posedge I_CORE_CLK);
   endtask

   task automatic wait_st(input logic [6:0] st, output int n);
      n = 0;
      while (O_STATE !== st && n < 3000)
      begin
         @(posedge I_CORE_CLK);
         n++;
      end
   endtask

   // Stop, then run with a new restart code and control mode
   task automatic restart(input logic [1:0] code, input logic [2:0] mode);
      I_RUN_COMMAND <= 1'b0;
      ticks(1);
      I_RESTART_FUNCTION_SELECT <= code;
      I_CONTROL_MODE_SELECT <= mode;
      I_RUN_COMMAND <= 1'b1;
      repeat (2) @(posedge I_CORE_CLK);
   endtask

   function automatic int found_speed(input int max, input int step, input int spd, input int f);
      longint acc;
      int n;
      acc = longint'(max) << 16;
      n = 0;
      while (acc > 0)
      begin
         n = ((acc >> 16) <= spd) ? n + 1 : 0;
         if (n >= f)
            return int'(acc >> 16);
         acc -= step;
      end
      return 0;
   endfunction

   function automatic logic [8:0] rec_factor(input logic [5:0] code);
      int edges[11] = '{21, 24, 27, 30, 33, 38, 41, 45, 49, 50, 51};
      rec_factor = 9'h03C;
      foreach (edges[i])
         if (code >= edges[i])
            rec_factor += 9'h00A;
   endfunction

   initial
   begin
      repeat (8) @(posedge I_CORE_CLK);
      I_RST_N <= 1'b1;
      I_GENERAL_ENABLE <= 1'b1;
      restart(2'h0, 3'h0);
      I_ZERO_SPEED_DISABLE_ON <= 1'b1;
      I_ZERO_SPEED_EXIT_SELECT <= 1'b1;
      I_SPEED_REFERENCE_VALUE <= 16'($unsigned($random(seed)) % 100);
      shaft <= 16'($unsigned($random(seed)) % 100);
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b1);
      chk(O_PULSE_ENABLE, 1'b0);
      shaft <= 16'h00C8;
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b1);
      I_PID_SELECT <= 2'h1;
      I_PID_AUTOMATIC <= 1'b1;
      I_PID_ERROR <= 17'h00014;
      I_SPEED_REFERENCE_VALUE <= 16'h0096;
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b1);
      I_PID_ERROR <= 17'h00015;
      ticks(3);
      chk(O_PULSE_ENABLE, 1'b1);
      I_PID_SELECT <= 2'h0;
      I_ZERO_SPEED_EXIT_SELECT <= 1'b0;
      I_SPEED_REFERENCE_VALUE <= 16'h0032;
      shaft <= 16'h0032;
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b1);
      shaft <= 16'h0065;
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b0);
      shaft <= 16'h0064;
      ticks(3);
      chk(O_ZERO_SPEED_DISABLED, 1'b0);
      I_ZERO_SPEED_DELAY <= 10'h001;
      shaft <= 16'h0032;
      ticks(500);
      shaft <= 16'h00C8;
      ticks(2);
      shaft <= 16'h0032;
      ticks(995);
      chk(O_ZERO_SPEED_DISABLED, 1'b0);
      ticks(10);
      chk(O_ZERO_SPEED_DISABLED, 1'b1);
      I_ZERO_SPEED_DISABLE_ON <= 1'b0;
      shaft <= 16'h0258;
      repeat (3) @(posedge I_CORE_CLK);
      chk(O_ZERO_SPEED_DISABLED, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         restart(2'(k), 3'h0);
         chk(O_STATE, (k == 1 || k == 2) ? zsfs_pkg::ST_DEAD : zsfs_pkg::ST_RUN);
      end
      I_SPEED_REFERENCE_VALUE <= 16'($unsigned($random(seed)) % 1800 + 1);
      restart(2'h1, 3'h0);
      chk(O_PULSE_ENABLE, 1'b0);
      wait_st(zsfs_pkg::ST_VRAMP, c);
      chk(c >= 790 && c <= 800, 1'b1);
      chk(O_OUTPUT_FREQUENCY, I_SPEED_REFERENCE_VALUE);
      wait_st(zsfs_pkg::ST_RUN, c);
      chk(c >= 1590 && c <= 1600, 1'b1);
      chk(O_RAMP_PERCENT, 7'h64);
      restart(2'h2, 3'h3);
      chk(O_STATE, zsfs_pkg::ST_IRAMP);
      chk(O_OUTPUT_FREQUENCY, 16'h03E8);
      chk(O_MAGNETIZE, 1'b0);
      wait_st(zsfs_pkg::ST_SWEEP, c);
      chk(c >= 72 && c <= 80, 1'b1);
      chk(O_RAMP_PERCENT, 7'h64);
      chk(O_SEARCH_ACTIVE, 1'b1);
      wait_st(zsfs_pkg::ST_RUN, c);
      c = int'(O_START_SPEED) - found_speed(1000, 100 * 6554, 600, 5);
      chk(c >= -10 && c <= 10, 1'b1);
      chk(O_VECTOR_CONTROL, 1'b1);
      I_DIGITAL_INPUT_FUNCTION <= 40'h0000006000;
      I_DIGITAL_INPUT <= 8'h04;
      restart(2'h1, 3'h3);
      chk(O_STATE, zsfs_pkg::ST_RUN);
      chk(O_RAMP_PERCENT, 7'h64);
      I_DIGITAL_INPUT <= 8'h00;
      restart(2'h1, 3'h4);
      chk(O_STATE, zsfs_pkg::ST_MAG);
      chk(O_MAGNETIZE, 1'b1);
      shaft <= 16'($unsigned($random(seed)) % 1800);
      wait_st(zsfs_pkg::ST_RUN, c);
      chk(O_START_SPEED, shaft);
      for (int k = 0; k < 12; k++)
      begin
         I_MOTOR_RATING_CODE <= (k < 4) ? 6'(20 + k * 10) : 6'($random(seed));
         repeat (3) @(posedge I_CORE_CLK);
         chk(O_RECOMMENDED_SWEEP_FACTOR, rec_factor(I_MOTOR_RATING_CODE));
      end
      print_verdict();
   end
endmodule
`default_nettype wire
